// [alarm_timer_pkg.sv]
package alarm_timer_pkg;

  localparam int          N_TIMERS      = 2;
  localparam logic [7:0]  TIMER_STRIDE  = 8'h24;

  localparam logic [7:0]  OFF_CONFIG    = 8'h00;
  localparam logic [7:0]  OFF_SNAP_LO   = 8'h04;
  localparam logic [7:0]  OFF_SNAP_HI   = 8'h08;
  localparam logic [7:0]  OFF_SNAP_TRIG = 8'h0C;
  localparam logic [7:0]  OFF_ALARM_LO  = 8'h10;
  localparam logic [7:0]  OFF_ALARM_HI  = 8'h14;
  localparam logic [7:0]  OFF_RELOAD_LO = 8'h18;
  localparam logic [7:0]  OFF_RELOAD_HI = 8'h1C;
  localparam logic [7:0]  OFF_RELOAD    = 8'h20;
  localparam logic [7:0]  OFF_INT_ENA   = 8'h98;
  localparam logic [7:0]  OFF_INT_RAW   = 8'h9C;
  localparam logic [7:0]  OFF_INT_ST    = 8'hA0;
  localparam logic [7:0]  OFF_INT_CLR   = 8'hA4;

  localparam int          CFG_EN        = 31;
  localparam int          CFG_UP        = 30;
  localparam int          CFG_AUTO      = 29;
  localparam int          CFG_DIV_MSB   = 28;
  localparam int          CFG_DIV_LSB   = 13;
  localparam int          CFG_EDGE      = 12;
  localparam int          CFG_LEVEL     = 11;
  localparam int          CFG_ARM       = 10;

  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [63:0] COUNT_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
  localparam logic [16:0] DIV_MAX       = 17'h10000;
  localparam logic [16:0] DIV_MIN       = 17'h00002;

  localparam int          IRQ_W         = 3;
  localparam int          IRQ_T0        = 0;
  localparam int          IRQ_T1        = 1;
  localparam int          IRQ_WDT       = 2;
  localparam logic [1:0]  WDT_STAGE_IRQ = 2'h1;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;

endpackage

// [tick_prescaler.sv]
`timescale 1ns/1ps
module tick_prescaler (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        run,
  input  wire logic [15:0] prescale_divisor,
  output logic             tick
);

  logic [16:0] div_count;
  logic [16:0] divisor_eff;

  // Divisor 0 means 65536, 1 and 2 both mean 2
  always_comb begin
    if (prescale_divisor == 16'h0000) begin
      divisor_eff = alarm_timer_pkg::DIV_MAX;
    end else if (prescale_divisor <= 16'h0002) begin
      divisor_eff = alarm_timer_pkg::DIV_MIN;
    end else begin
      divisor_eff = {1'b0, prescale_divisor};
    end
  end

  // One tick every divisor_eff cycles while running; phase held when stopped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_count <= 17'h00000;
      tick      <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (run) begin
        if (div_count >= divisor_eff - 17'h00001) begin
          div_count <= 17'h00000;
          tick      <= 1'b1;
        end else begin
          div_count <= div_count + 17'h00001;
        end
      end
    end
  end

endmodule

// [time_base_counter.sv]
`timescale 1ns/1ps
module time_base_counter (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        tick,
  input  wire logic        count_enable,
  input  wire logic        count_up_select,
  input  wire logic        reload_on_alarm,
  input  wire logic        alarm_arm,
  input  wire logic [63:0] alarm_value,
  input  wire logic [63:0] reload_value,
  input  wire logic        reload_now,
  output logic      [63:0] count_value,
  output logic             alarm_event
);

  // Match or already passed in the present direction, only while armed
  always_comb begin
    if (count_up_select) begin
      alarm_event = alarm_arm && (count_value >= alarm_value);
    end else begin
      alarm_event = alarm_arm && (count_value <= alarm_value);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_value <= alarm_timer_pkg::COUNT_RESET;
    end else if (reload_now) begin
      count_value <= reload_value;
    end else if (alarm_event && reload_on_alarm) begin
      count_value <= reload_value;
    end else if (count_enable && tick) begin
      if (count_up_select) begin
        count_value <= count_value + 64'h0000_0000_0000_0001;
      end else begin
        count_value <= count_value - 64'h0000_0000_0000_0001;
      end
    end
  end

endmodule

// [alarm_timer_64bit.sv]
`timescale 1ns/1ps
// Summary of operation
// - Two independent timers, each a 16-bit prescaler feeding a reloadable 64-bit counter.
// - Each prescaler tick moves the counter by exactly one in the selected direction.
// - Divisor is the programmed value; 1 or 2 gives 2, 0 gives 65536.
// - Direction bit set counts up, clear counts down, effective immediately.
// - With count enable clear the counter holds and later resumes from there.
// - Reload while disabled changes the value but counting stays halted.
// - Reload value writes alone leave the counter; only reload events copy them.
// - Reload-on-alarm reloads at alarm; otherwise counting continues past the alarm.
// - Any write to the reload trigger loads the reload value immediately.
// - Any write to the snapshot trigger latches the counter into both readback words.
// - Alarm fires when the 64-bit alarm value equals the counter.
// - Alarm also fires at once if the counter already passed the alarm value.
// - Timer 0 and timer 1 alarms raise their own interrupts; reloads raise none.
// - A watchdog stage timeout configured for interrupt raises a separate interrupt.
// - Each timer signals its alarm as level or edge, selected separately.
// - Alarms occur only while the alarm arm bit is set.
// - Edge and level select bits each enable that interrupt form.
module alarm_timer_64bit (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        watchdog_stage_timeout,
  input  wire logic [1:0]  watchdog_stage_mode,
  output logic             irq,
  output logic      [1:0]  alarm_pulse
);

  localparam int NT = alarm_timer_pkg::N_TIMERS;

  alarm_timer_pkg::bus_state_t state;

  logic                  take;
  logic                  wr_pend;
  logic [7:0]            wr_addr;
  logic [7:0]            rd_addr;
  logic [31:0]           next_rdata;

  logic [NT-1:0]         count_enable;
  logic [NT-1:0]         count_up_select;
  logic [NT-1:0]         reload_on_alarm;
  logic [NT-1:0]         pulse_irq_select;
  logic [NT-1:0]         held_irq_select;
  logic [NT-1:0]         alarm_arm;
  logic [15:0]           prescale_divisor  [NT];
  logic [31:0]           alarm_value_low   [NT];
  logic [31:0]           alarm_value_high  [NT];
  logic [31:0]           reload_value_low  [NT];
  logic [31:0]           reload_value_high [NT];
  logic [31:0]           snapshot_low      [NT];
  logic [31:0]           snapshot_high     [NT];
  logic [63:0]           count_value       [NT];
  logic [NT-1:0]         tick;
  logic [NT-1:0]         alarm_event;
  logic [NT-1:0]         reload_trigger;
  logic [NT-1:0]         snapshot_trigger;
  logic [NT-1:0]         config_write;

  logic [alarm_timer_pkg::IRQ_W-1:0] int_raw;
  logic [alarm_timer_pkg::IRQ_W-1:0] int_ena;
  logic [alarm_timer_pkg::IRQ_W-1:0] int_set;
  logic [alarm_timer_pkg::IRQ_W-1:0] int_clr;

  function automatic logic reg_hit(
    input logic [7:0] addr,
    input logic [7:0] off,
    input int         idx
  );
    logic [7:0] base;
    base = 8'(idx) * alarm_timer_pkg::TIMER_STRIDE;
    return addr == (off + base);
  endfunction

  assign take = hsel && hready && htrans[1];

  // Address phase capture for writes; data applied in the following cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= take && hwrite;
      if (take && hwrite) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Reads take one wait state so a preceding write is visible
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state     <= alarm_timer_pkg::BUS_IDLE;
      hreadyout <= 1'b1;
      hrdata    <= alarm_timer_pkg::WORD_RESET;
      rd_addr   <= 8'h00;
    end else begin
      unique case (state)
        alarm_timer_pkg::BUS_IDLE: begin
          if (take && !hwrite) begin
            state     <= alarm_timer_pkg::BUS_READ;
            hreadyout <= 1'b0;
            rd_addr   <= haddr[7:0];
          end
        end
        alarm_timer_pkg::BUS_READ: begin
          state     <= alarm_timer_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= next_rdata;
        end
        default: begin
          state     <= alarm_timer_pkg::BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Always OKAY
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  genvar x;
  generate
    for (x = 0; x < NT; x++) begin : g_timer
      assign config_write[x]     = wr_pend && reg_hit(wr_addr, alarm_timer_pkg::OFF_CONFIG, x);
      assign reload_trigger[x]   = wr_pend && reg_hit(wr_addr, alarm_timer_pkg::OFF_RELOAD, x);
      assign snapshot_trigger[x] = wr_pend && reg_hit(wr_addr, alarm_timer_pkg::OFF_SNAP_TRIG, x);

      // Configuration; the arm bit drops after an alarm unless rewritten
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          count_enable[x]     <= 1'b0;
          count_up_select[x]  <= 1'b0;
          reload_on_alarm[x]  <= 1'b0;
          prescale_divisor[x] <= alarm_timer_pkg::DIVISOR_RESET;
          pulse_irq_select[x] <= 1'b0;
          held_irq_select[x]  <= 1'b0;
          alarm_arm[x]        <= 1'b0;
        end else if (config_write[x]) begin
          count_enable[x]     <= hwdata[alarm_timer_pkg::CFG_EN];
          count_up_select[x]  <= hwdata[alarm_timer_pkg::CFG_UP];
          reload_on_alarm[x]  <= hwdata[alarm_timer_pkg::CFG_AUTO];
          prescale_divisor[x] <=
            hwdata[alarm_timer_pkg::CFG_DIV_MSB:alarm_timer_pkg::CFG_DIV_LSB];
          pulse_irq_select[x] <= hwdata[alarm_timer_pkg::CFG_EDGE];
          held_irq_select[x]  <= hwdata[alarm_timer_pkg::CFG_LEVEL];
          alarm_arm[x]        <= hwdata[alarm_timer_pkg::CFG_ARM];
        end else if (alarm_event[x]) begin
          alarm_arm[x] <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          alarm_value_low[x]   <= alarm_timer_pkg::WORD_RESET;
          alarm_value_high[x]  <= alarm_timer_pkg::WORD_RESET;
          reload_value_low[x]  <= alarm_timer_pkg::WORD_RESET;
          reload_value_high[x] <= alarm_timer_pkg::WORD_RESET;
        end else if (wr_pend) begin
          if (reg_hit(wr_addr, alarm_timer_pkg::OFF_ALARM_LO, x)) begin
            alarm_value_low[x] <= hwdata;
          end
          if (reg_hit(wr_addr, alarm_timer_pkg::OFF_ALARM_HI, x)) begin
            alarm_value_high[x] <= hwdata;
          end
          if (reg_hit(wr_addr, alarm_timer_pkg::OFF_RELOAD_LO, x)) begin
            reload_value_low[x] <= hwdata;
          end
          if (reg_hit(wr_addr, alarm_timer_pkg::OFF_RELOAD_HI, x)) begin
            reload_value_high[x] <= hwdata;
          end
        end
      end

      // Coherent 64-bit latch for two word reads
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          snapshot_low[x]  <= alarm_timer_pkg::WORD_RESET;
          snapshot_high[x] <= alarm_timer_pkg::WORD_RESET;
        end else if (snapshot_trigger[x]) begin
          snapshot_low[x]  <= count_value[x][31:0];
          snapshot_high[x] <= count_value[x][63:32];
        end
      end

      tick_prescaler u_prescaler (
        .clk              (clk),
        .rst_b            (rst_b),
        .run              (count_enable[x]),
        .prescale_divisor (prescale_divisor[x]),
        .tick             (tick[x])
      );

      time_base_counter u_counter (
        .clk             (clk),
        .rst_b           (rst_b),
        .tick            (tick[x]),
        .count_enable    (count_enable[x]),
        .count_up_select (count_up_select[x]),
        .reload_on_alarm (reload_on_alarm[x]),
        .alarm_arm       (alarm_arm[x]),
        .alarm_value     ({alarm_value_high[x], alarm_value_low[x]}),
        .reload_value    ({reload_value_high[x], reload_value_low[x]}),
        .reload_now      (reload_trigger[x]),
        .count_value     (count_value[x]),
        .alarm_event     (alarm_event[x])
      );

      // Edge form: one-cycle pulse per alarm
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          alarm_pulse[x] <= 1'b0;
        end else begin
          alarm_pulse[x] <= alarm_event[x] && pulse_irq_select[x];
        end
      end

      // Level form: alarm sets the sticky status bit
      assign int_set[x] = alarm_event[x] && held_irq_select[x];
    end
  endgenerate

  assign int_set[alarm_timer_pkg::IRQ_WDT] =
    watchdog_stage_timeout && (watchdog_stage_mode == alarm_timer_pkg::WDT_STAGE_IRQ);

  assign int_clr = (wr_pend && (wr_addr == alarm_timer_pkg::OFF_INT_CLR)) ?
                   hwdata[alarm_timer_pkg::IRQ_W-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_raw <= '0;
    end else begin
      int_raw <= (int_raw & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      int_ena <= '0;
    end else if (wr_pend && (wr_addr == alarm_timer_pkg::OFF_INT_ENA)) begin
      int_ena <= hwdata[alarm_timer_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_raw & int_ena);
    end
  end

  // Read mux; triggers, clear and unmapped addresses read zero
  always_comb begin
    next_rdata = alarm_timer_pkg::WORD_RESET;
    for (int i = 0; i < NT; i++) begin
      if (reg_hit(rd_addr, alarm_timer_pkg::OFF_CONFIG, i)) begin
        next_rdata[alarm_timer_pkg::CFG_EN]    = count_enable[i];
        next_rdata[alarm_timer_pkg::CFG_UP]    = count_up_select[i];
        next_rdata[alarm_timer_pkg::CFG_AUTO]  = reload_on_alarm[i];
        next_rdata[alarm_timer_pkg::CFG_DIV_MSB:alarm_timer_pkg::CFG_DIV_LSB] =
          prescale_divisor[i];
        next_rdata[alarm_timer_pkg::CFG_EDGE]  = pulse_irq_select[i];
        next_rdata[alarm_timer_pkg::CFG_LEVEL] = held_irq_select[i];
        next_rdata[alarm_timer_pkg::CFG_ARM]   = alarm_arm[i];
      end
      if (reg_hit(rd_addr, alarm_timer_pkg::OFF_SNAP_LO, i)) begin
        next_rdata = snapshot_low[i];
      end
      if (reg_hit(rd_addr, alarm_timer_pkg::OFF_SNAP_HI, i)) begin
        next_rdata = snapshot_high[i];
      end
      if (reg_hit(rd_addr, alarm_timer_pkg::OFF_ALARM_LO, i)) begin
        next_rdata = alarm_value_low[i];
      end
      if (reg_hit(rd_addr, alarm_timer_pkg::OFF_ALARM_HI, i)) begin
        next_rdata = alarm_value_high[i];
      end
      if (reg_hit(rd_addr, alarm_timer_pkg::OFF_RELOAD_LO, i)) begin
        next_rdata = reload_value_low[i];
      end
      if (reg_hit(rd_addr, alarm_timer_pkg::OFF_RELOAD_HI, i)) begin
        next_rdata = reload_value_high[i];
      end
    end
    if (rd_addr == alarm_timer_pkg::OFF_INT_ENA) begin
      next_rdata[alarm_timer_pkg::IRQ_W-1:0] = int_ena;
    end
    if (rd_addr == alarm_timer_pkg::OFF_INT_RAW) begin
      next_rdata[alarm_timer_pkg::IRQ_W-1:0] = int_raw;
    end
    if (rd_addr == alarm_timer_pkg::OFF_INT_ST) begin
      next_rdata[alarm_timer_pkg::IRQ_W-1:0] = int_raw & int_ena;
    end
  end

endmodule

// [alarm_timer_checker_assertions.sv]
`timescale 1ns/1ps
module alarm_timer_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq,
  input wire logic [1:0]  alarm_pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  logic rd_t;
  logic wr_t;
  assign rd_t = hsel && hready && htrans[1] && !hwrite;
  assign wr_t = hsel && hready && htrans[1] && hwrite;

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_read_wait: assert property (rd_t |=> !hreadyout ##1 hreadyout)
    else $error("read wait");
  a_write_nowait: assert property (wr_t |=> hreadyout)
    else $error("write wait");
  a_wait_single: assert property (!hreadyout |=> hreadyout)
    else $error("long wait");
  a_wait_cause: assert property ($fell(hreadyout) |-> $past(rd_t))
    else $error("stray wait");
  a_data_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("hrdata moved");
  a_irq_fall: assert property ($fell(irq) |-> $past(wr_t, 3))
    else $error("irq fell alone");
  a_reset_quiet: assert property (
    $rose(rst_b) |-> hreadyout && !irq && alarm_pulse == 2'h0)
    else $error("outputs after reset");
  a_pulse_single: assert property (alarm_pulse[0] |=> !alarm_pulse[0])
    else $error("edge alarm longer than one cycle");

  cover property (rd_t);
  cover property (alarm_pulse[0]);
  cover property (alarm_pulse[1]);
  cover property ($rose(irq));
endmodule

bind alarm_timer_64bit alarm_timer_checker alarm_timer_checker_i (
  .clk, .rst_b, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .irq,
  .alarm_pulse
);

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        hsel = 1'b1;
  logic        hwrite = 1'b0;
  logic        wd_to = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [1:0]  wd_mode = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [63:0] v0;
  logic [63:0] v1;
  logic [1:0]  pulse;
  logic        hreadyout;
  logic        irq;
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          t_wr = 0;
  int          np0 = 0;
  int          n;

  alarm_timer_64bit alarm_timer_64bit_i (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .watchdog_stage_timeout(wd_to),
    .watchdog_stage_mode(wd_mode), .irq(irq), .alarm_pulse(pulse)
  );

  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) np0 <= np0 + int'(pulse[0] === 1'b1);

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wt();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k == 20) chk("hready", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    t_wr = cyc;
  endtask

  task automatic rdw(input logic [7:0] a);
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wt();
    htrans <= 2'h0;
    wt();
    rd = hrdata;
  endtask

  task automatic rck(input string s, input logic [7:0] a, input logic [31:0] e);
    rdw(a);
    chk(s, e, rd);
  endtask

  task automatic snap(input logic [7:0] b, output logic [63:0] v);
    wr(b + 8'h0C, 32'h0);
    rdw(b + 8'h04);
    v[31:0] = rd;
    rdw(b + 8'h08);
    v[63:32] = rd;
  endtask

  // Two snapshots exactly k*d cycles apart must differ by k
  task automatic steps(input logic [7:0] b, input int k, input int d, input logic up);
    logic [63:0] s;
    logic [63:0] e;
    int c0;
    snap(b, s);
    c0 = t_wr;
    while (cyc < c0 + k * d - 2) @(posedge clk);
    snap(b, e);
    chk("span", c0 + k * d, t_wr);
    s = up ? s + 64'(k) : s - 64'(k);
    chk("count_lo", s[31:0], e[31:0]);
    chk("count_hi", s[63:32], e[63:32]);
  endtask

  task automatic wp(input int b, input int lim);
    n = 0;
    while (pulse[b] !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic t_reset();
    rck("cfg0", 8'h00, 32'h0000_2000);
    rck("cfg1", 8'h24, 32'h0000_2000);
    rck("raw", 8'h9C, 32'h0);
    wr(8'h80, 32'hFFFF_FFFF);
    rck("unmapped", 8'h80, 32'h0);
    wr(8'h04, 32'h1234_5678);
    rck("snap_ro", 8'h04, 32'h0);
    wr(8'h10, 32'hA5A5_5A5A);
    rck("alarm_rw", 8'h10, 32'hA5A5_5A5A);
    $display("t_reset done");
  endtask

  task automatic t_div();
    logic [15:0] dv[4] = '{16'h0001, 16'h0002, 16'h0005, 16'h0000};
    int          dd[4] = '{2, 2, 5, 65536};
    int          kk[4] = '{6, 6, 4, 1};
    logic [15:0] pd = 16'h0001;
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {3'b000, pd, 13'h0});
      wr(8'h00, {1'b1, i[1], 1'b0, dv[i], 13'h0});
      steps(8'h00, kk[i], dd[i], i[1]);
      pd = dv[i];
    end
    $display("t_div done");
  endtask

  task automatic t_hold();
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h0000_4000);
    snap(8'h00, v0);
    repeat (20) @(posedge clk);
    snap(8'h00, v1);
    chk("frozen", v0[31:0], v1[31:0]);
    wr(8'h18, 32'hFFFF_FFF8);
    wr(8'h1C, 32'hFFFF_FFFF);
    snap(8'h00, v1);
    chk("no_load", v0[31:0], v1[31:0]);
    wr(8'h20, 32'h0);
    repeat (20) @(posedge clk);
    snap(8'h00, v1);
    chk("load_lo", 32'hFFFF_FFF8, v1[31:0]);
    chk("load_hi", 32'hFFFF_FFFF, v1[63:32]);
    wr(8'h00, 32'hC000_4000);
    steps(8'h00, 8, 2, 1'b1);
    wr(8'h00, 32'h8000_4000);
    steps(8'h00, 6, 2, 1'b0);
    $display("t_hold done");
  endtask

  task automatic t_alarm();
    int p;
    wr(8'h00, 32'h0000_4000);
    wr(8'h18, 32'h0);
    wr(8'h1C, 32'h0);
    wr(8'h20, 32'h0);
    wr(8'h10, 32'h14);
    wr(8'h14, 32'h0);
    wr(8'h98, 32'h7);
    wr(8'h00, 32'hE000_5C00);
    wp(0, 100);
    chk("alarm_time", 32'h1, 32'(n > 30 && n < 60));
    @(posedge clk);
    chk("irq_t0", 32'h1, {31'h0, irq});
    rck("raw_t0", 8'h9C, 32'h1);
    rck("st_t0", 8'hA0, 32'h1);
    rck("arm_clr", 8'h00, 32'hE000_5800);
    snap(8'h00, v0);
    chk("reloaded", 32'h1, 32'(v0[31:0] < 32'h14));
    wr(8'hA4, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    p = np0;
    repeat (60) @(posedge clk);
    chk("disarmed", p, np0);
    rck("raw_none", 8'h9C, 32'h0);
    wr(8'h00, 32'hC000_4C00);
    repeat (3) @(posedge clk);
    rck("raw_late", 8'h9C, 32'h1);
    chk("no_pulse", p, np0);
    steps(8'h00, 6, 2, 1'b1);
    wr(8'h98, 32'h0);
    repeat (2) @(posedge clk);
    chk("masked", 32'h0, {31'h0, irq});
    rck("st_masked", 8'hA0, 32'h0);
    wr(8'h98, 32'h7);
    repeat (2) @(posedge clk);
    chk("unmasked", 32'h1, {31'h0, irq});
    wr(8'hA4, 32'h7);
    $display("t_alarm done");
  endtask

  task automatic t_tmr1();
    wr(8'h24, 32'h0000_4000);
    wr(8'h3C, 32'h64);
    wr(8'h40, 32'h0);
    wr(8'h44, 32'h0);
    wr(8'h34, 32'h1E);
    wr(8'h38, 32'h0);
    wr(8'h24, 32'h8000_5400);
    wp(1, 300);
    chk("alarm1_time", 32'h1, 32'(n > 120 && n < 160));
    chk("pulse0_idle", 32'h0, {31'h0, pulse[0]});
    rck("raw_t1", 8'h9C, 32'h0);
    wr(8'h24, 32'h8000_4C00);
    repeat (3) @(posedge clk);
    rck("raw_t1_late", 8'h9C, 32'h2);
    wr(8'hA4, 32'h2);
    $display("t_tmr1 done");
  endtask

  task automatic t_wd();
    for (int m = 2; m > 0; m--) begin
      wd_mode <= 2'(m);
      wd_to <= 1'b1;
      @(posedge clk);
      wd_to <= 1'b0;
      repeat (3) @(posedge clk);
      rck("wd_raw", 8'h9C, (m == 1) ? 32'h4 : 32'h0);
    end
    chk("wd_irq", 32'h1, {31'h0, irq});
    wr(8'hA4, 32'h4);
    repeat (2) @(posedge clk);
    chk("wd_clr", 32'h0, {31'h0, irq});
    $display("t_wd done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_div();
    t_hold();
    t_alarm();
    t_tmr1();
    t_wd();
    end_sim();
  end

  initial begin
    #9_000_000;
    fails++;
    $display("[ERR] run expected done seen timeout");
    end_sim();
  end
endmodule
